// ### design/afh_pkg.sv
// package: constants and carrier types for the asynchronous fifo host port
package afh_pkg;
  localparam int DATA_W = 8;
  localparam int TX_DEPTH = 16;
  localparam int TX_PTR_W = 4;
  localparam logic [1:0] SYNC_RESET = 2'h3;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic FLAG_IDLE = 1'h1;
  // channel port mode taken from nonvolatile configuration
  typedef enum logic [1:0] {
    AFH_MODE_OFF = 2'h0,
    AFH_MODE_FIFO = 2'h1
  } afh_mode_t;
  // read strobe cycle states, one bit changes per step except hold back to idle
  typedef enum logic [1:0] {
    AFH_RD_IDLE = 2'b00,
    AFH_RD_DRIVE = 2'b01,
    AFH_RD_HOLD = 2'b11
  } afh_rd_state_t;
  // byte stream carrier between the port and the usb engine
  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] data;
  } afh_byte_t;
  // usb side control requests
  typedef struct packed {
    logic resume_req;
    logic send_now;
  } afh_usb_req_t;
endpackage : afh_pkg

// ### design/afh_fifo.sv
// module: parameterised flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module afh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int PTR_W = 4
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PTR_W-1:0] wr_ptr_r;
  logic [PTR_W-1:0] rd_ptr_r;
  logic [PTR_W:0] count_r;
  logic push;
  logic pop;

  // honest full and empty from the occupancy count
  assign in_ready = (count_r != (PTR_W+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + PTR_W'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + PTR_W'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (PTR_W+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (PTR_W+1)'(1);
      end
    end
  end
endmodule : afh_fifo
`default_nettype wire

// ### design/afh_port.sv
// module: one channel of the asynchronous byte-wide fifo host port
// What this block does
// - port active only when configured fifo mode
// - bus input except while read strobe low
// - receive flag low when byte waiting
// - receive flag forced high after each read
// - read strobe rise advances receive buffer
// - transmit flag low when space available
// - write strobe fall captures data byte
// - flags undriven during reset, weak pull-up
// - suspended, wake pulse requests usb resume
// - active, wake pulse flushes transmit data
`timescale 1ns/1ps
`default_nettype none
module afh_port (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire afh_pkg::afh_mode_t cfg_mode,
  input wire logic cfg_remote_wake_en,
  input wire logic power_active_n,
  input wire logic [afh_pkg::DATA_W-1:0] data_bus_in,
  output logic [afh_pkg::DATA_W-1:0] data_bus_out,
  output logic data_bus_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic send_now_wake_n,
  output logic rx_avail_n,
  output logic rx_avail_oe,
  output logic tx_space_n,
  output logic tx_space_oe,
  input wire afh_pkg::afh_byte_t rx_byte,
  output logic rx_byte_ready,
  output afh_pkg::afh_byte_t tx_byte,
  input wire logic tx_byte_ready,
  output afh_pkg::afh_usb_req_t usb_req
);
  logic port_on;
  logic [1:0] rd_sync_r;
  logic [1:0] wr_sync_r;
  logic [1:0] wake_sync_r;
  logic rd_prev_r;
  logic wr_prev_r;
  logic wake_prev_r;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wake_fall;
  afh_pkg::afh_rd_state_t rd_state_r;
  afh_pkg::afh_rd_state_t rd_state_nxt;
  logic [afh_pkg::DATA_W-1:0] wr_data_r;
  logic tx_push_r;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [afh_pkg::DATA_W-1:0] fifo_out_data;
  logic fifo_out_ready;
  logic tx_out_valid_r;
  logic [afh_pkg::DATA_W-1:0] tx_out_data_r;

  assign port_on = (cfg_mode == afh_pkg::AFH_MODE_FIFO);

  // two-stage strobe synchronisers, first stage read only by the second
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_sync_r <= afh_pkg::SYNC_RESET;
      wr_sync_r <= afh_pkg::SYNC_RESET;
      wake_sync_r <= afh_pkg::SYNC_RESET;
    end else begin
      rd_sync_r <= {rd_sync_r[0], rd_n};
      wr_sync_r <= {wr_sync_r[0], wr_n};
      wake_sync_r <= {wake_sync_r[0], send_now_wake_n};
    end
  end

  // previous synchronised levels for edge detection
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_prev_r <= afh_pkg::FLAG_IDLE;
      wr_prev_r <= afh_pkg::FLAG_IDLE;
      wake_prev_r <= afh_pkg::FLAG_IDLE;
    end else begin
      rd_prev_r <= rd_sync_r[1];
      wr_prev_r <= wr_sync_r[1];
      wake_prev_r <= wake_sync_r[1];
    end
  end

  // one-cycle edge pulses, exactly one per strobe pulse
  assign rd_fall = port_on && rd_prev_r && !rd_sync_r[1];
  assign rd_rise = port_on && !rd_prev_r && rd_sync_r[1];
  assign wr_fall = port_on && wr_prev_r && !wr_sync_r[1];
  assign wake_fall = port_on && wake_prev_r && !wake_sync_r[1];

  // read cycle sequence: drive on fall, advance on rise
  always_comb begin
    rd_state_nxt = rd_state_r;
    case (rd_state_r)
      afh_pkg::AFH_RD_IDLE: begin
        if (rd_fall) begin
          rd_state_nxt = afh_pkg::AFH_RD_DRIVE;
        end
      end
      afh_pkg::AFH_RD_DRIVE: begin
        if (rd_rise) begin
          rd_state_nxt = afh_pkg::AFH_RD_HOLD;
        end
      end
      afh_pkg::AFH_RD_HOLD: begin
        rd_state_nxt = afh_pkg::AFH_RD_IDLE;
      end
      default: begin
        rd_state_nxt = afh_pkg::AFH_RD_IDLE;
      end
    endcase
    // leaving fifo mode mid-strobe must not strand the sequence in drive
    if (!port_on) begin
      rd_state_nxt = afh_pkg::AFH_RD_IDLE;
    end
  end

  // read state register
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rd_state_r <= afh_pkg::AFH_RD_IDLE;
    end else begin
      rd_state_r <= rd_state_nxt;
    end
  end

  // pop the receive byte once the strobe returns high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_byte_ready <= 1'b0;
    end else begin
      rx_byte_ready <= (rd_state_r == afh_pkg::AFH_RD_DRIVE) && rd_rise;
    end
  end

  // data bus drive: output only while the read strobe is low
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      data_bus_oe <= 1'b0;
      data_bus_out <= afh_pkg::BYTE_ZERO;
    end else begin
      data_bus_oe <= port_on && !rd_sync_r[1];
      if (rd_state_r == afh_pkg::AFH_RD_IDLE) begin
        data_bus_out <= rx_byte.data; // frozen while the strobe is low
      end
    end
  end

  // receive flag: low when a byte waits, forced high for two cycles after read
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_avail_n <= afh_pkg::FLAG_IDLE;
    end else begin
      if (!port_on || rd_rise || rx_byte_ready) begin
        rx_avail_n <= afh_pkg::FLAG_IDLE;
      end else if (rd_state_r == afh_pkg::AFH_RD_IDLE) begin
        rx_avail_n <= !rx_byte.valid;
      end
    end
  end

  // capture the write byte on the synchronised falling edge
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wr_data_r <= afh_pkg::BYTE_ZERO;
      tx_push_r <= 1'b0;
    end else begin
      tx_push_r <= wr_fall && fifo_in_ready;
      if (wr_fall) begin
        wr_data_r <= data_bus_in;
      end
    end
  end

  // transmit flag: low while the fifo has space and no byte is pending
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_space_n <= afh_pkg::FLAG_IDLE;
    end else begin
      tx_space_n <= !(port_on && fifo_in_ready && !wr_fall && !tx_push_r);
    end
  end

  // wake input: resume when suspended, flush when active
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      usb_req <= '0;
    end else begin
      usb_req.resume_req <= wake_fall && power_active_n && cfg_remote_wake_en;
      usb_req.send_now <= wake_fall && !power_active_n;
    end
  end

  // flag pin drivers: released in reset so the pull-ups hold the pins high
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rx_avail_oe <= 1'b0;
      tx_space_oe <= 1'b0;
    end else begin
      rx_avail_oe <= port_on;
      tx_space_oe <= port_on;
    end
  end

  // transmit buffer toward the usb engine
  afh_fifo #(
    .WIDTH(afh_pkg::DATA_W),
    .DEPTH(afh_pkg::TX_DEPTH),
    .PTR_W(afh_pkg::TX_PTR_W)
  ) u_tx_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .in_valid(tx_push_r),
    .in_ready(fifo_in_ready),
    .in_data(wr_data_r),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // output stage takes a new head whenever it is empty or being emptied
  assign fifo_out_ready = !tx_out_valid_r || tx_byte_ready;

  // output stage valid: set on a load, cleared when the engine takes the byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_out_valid_r <= 1'b0;
    end else begin
      if (fifo_out_valid && fifo_out_ready) begin
        tx_out_valid_r <= 1'b1;
      end else if (tx_byte_ready) begin
        tx_out_valid_r <= 1'b0;
      end
    end
  end

  // output stage data: moves only on a load so the engine sees a steady byte
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tx_out_data_r <= afh_pkg::BYTE_ZERO;
    end else begin
      if (fifo_out_valid && fifo_out_ready) begin
        tx_out_data_r <= fifo_out_data;
      end
    end
  end

  // usb-side byte comes straight from the output stage flops
  assign tx_byte.valid = tx_out_valid_r;
  assign tx_byte.data = tx_out_data_r;
endmodule : afh_port
`default_nettype wire

// ### verif/afh_port_monitor.sv
// checker: port timing of the fifo host port
`timescale 1ns/1ps
`default_nettype none
module afh_port_monitor (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire afh_pkg::afh_mode_t cfg_mode,
  input wire logic cfg_remote_wake_en,
  input wire logic power_active_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_bus_oe,
  input wire logic rx_avail_n,
  input wire logic rx_avail_oe,
  input wire logic tx_space_n,
  input wire logic tx_space_oe,
  input wire afh_pkg::afh_byte_t rx_byte,
  input wire logic rx_byte_ready,
  input wire afh_pkg::afh_byte_t tx_byte,
  input wire afh_pkg::afh_usb_req_t usb_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic fifo_on = cfg_mode == afh_pkg::AFH_MODE_FIFO;
  // strobe edges as sampled at the pins
  sequence rd_up; !rd_n ##1 rd_n; endsequence
  sequence wr_dn; wr_n ##1 !wr_n; endsequence
  a_oe_release: assert property ($rose(resetn) |-> !rx_avail_oe && !tx_space_oe)
    else $error("flag driven at reset");
  a_bus_drive: assert property (data_bus_oe |-> !$past(rd_n, 3))
    else $error("bus driven without read");
  a_rd_pop: assert property (rd_up ##0 rx_byte.valid |-> ##[2:5] rx_byte_ready)
    else $error("read rise did not pop");
  a_rx_drop: assert property (rd_up |-> ##[2:5] rx_avail_n)
    else $error("receive flag not forced high");
  a_rx_cause: assert property (!rx_avail_n |-> $past(rx_byte.valid))
    else $error("receive flag without byte");
  a_tx_busy: assert property (wr_dn ##0 fifo_on |-> ##[2:5] tx_space_n)
    else $error("transmit flag stayed low");
  a_tx_push: assert property (wr_dn ##0 (fifo_on && !tx_space_n) |-> ##[2:6] tx_byte.valid)
    else $error("write not captured");
  a_wake_why: assert property (usb_req.resume_req |-> power_active_n && cfg_remote_wake_en)
    else $error("resume while not allowed");
  a_send_why: assert property (usb_req.send_now |-> !power_active_n)
    else $error("flush while suspended");
  a_mode_off: assert property ((!fifo_on) [*2] |-> rx_avail_n && tx_space_n && !data_bus_oe)
    else $error("port active while off");
endmodule : afh_port_monitor
bind afh_port afh_port_monitor mon_u (
  .ref_clk(ref_clk),
  .resetn(resetn),
  .cfg_mode(cfg_mode),
  .cfg_remote_wake_en(cfg_remote_wake_en),
  .power_active_n(power_active_n),
  .rd_n(rd_n),
  .wr_n(wr_n),
  .data_bus_oe(data_bus_oe),
  .rx_avail_n(rx_avail_n),
  .rx_avail_oe(rx_avail_oe),
  .tx_space_n(tx_space_n),
  .tx_space_oe(tx_space_oe),
  .rx_byte(rx_byte),
  .rx_byte_ready(rx_byte_ready),
  .tx_byte(tx_byte),
  .usb_req(usb_req)
);
`default_nettype wire

// ### verif/afh_host_model.sv
// partner: external controller strobing the fifo host port
`timescale 1ns/1ps
`default_nettype none
module afh_host_model (
  input wire logic ref_clk,
  input wire logic rx_avail_n,
  input wire logic tx_space_n,
  input wire logic [7:0] dev_data,
  input wire logic dev_oe,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] bus
);
  logic [7:0] host_d;
  logic host_oe;
  // shared bus level; nobody driving shows the inverse of the last byte
  always_comb bus = dev_oe ? dev_data : host_oe ? host_d : ~host_d;
  // strobes idle high
  initial begin
    rd_n = 1'b1;
    wr_n = 1'b1;
    host_d = 8'h00;
    host_oe = 1'b0;
  end
  // bounded wait for an active-low flag
  task automatic wait_low(input bit use_rx, output logic ok);
    int n;
    n = 0;
    while ((use_rx ? rx_avail_n : tx_space_n) !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      n++;
    end
    ok = n < 400;
  endtask : wait_low
  // one read strobe, byte taken just before the rise
  task automatic rd_byte(input int hold, output logic [7:0] d, output logic ok);
    wait_low(1'b1, ok);
    rd_n <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    d = bus;
    rd_n <= 1'b1;
    repeat (hold + 2) @(posedge ref_clk);
  endtask : rd_byte
  // one write strobe, data held past the capture point
  task automatic wr_byte(input int hold, input logic [7:0] v, output logic ok);
    wait_low(1'b0, ok);
    host_d <= v;
    host_oe <= 1'b1;
    wr_n <= 1'b0;
    repeat (hold) @(posedge ref_clk);
    wr_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (hold) @(posedge ref_clk);
  endtask : wr_byte
endmodule : afh_host_model
`default_nettype wire

// ### verif/afh_port_tb.sv
// testbench: random and corner traffic through the fifo host port
`timescale 1ns/1ps
`default_nettype none
module afh_port_tb;
  logic ref_clk, resetn, cfg_remote_wake_en, power_active_n, send_now_wake_n, ok;
  logic rd_n, wr_n, data_bus_oe, rx_avail_n, rx_avail_oe, tx_space_n, tx_space_oe;
  logic rx_byte_ready, tx_byte_ready, drain_on;
  logic [7:0] data_bus_in, data_bus_out, d;
  logic [15:0] seed;
  logic [7:0] rx_q[$], rx_exp[$], tx_exp[$];
  int err_total, cmp_count, n_res, n_snd, r0, s0;
  afh_pkg::afh_mode_t cfg_mode;
  afh_pkg::afh_byte_t rx_byte, tx_byte;
  afh_pkg::afh_usb_req_t usb_req;
  wire logic rxf = rx_avail_oe ? rx_avail_n : 1'b1;
  wire logic txe = tx_space_oe ? tx_space_n : 1'b1;
  afh_port dut_u (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .cfg_mode(cfg_mode),
    .cfg_remote_wake_en(cfg_remote_wake_en),
    .power_active_n(power_active_n),
    .data_bus_in(data_bus_in),
    .data_bus_out(data_bus_out),
    .data_bus_oe(data_bus_oe),
    .rd_n(rd_n),
    .wr_n(wr_n),
    .send_now_wake_n(send_now_wake_n),
    .rx_avail_n(rx_avail_n),
    .rx_avail_oe(rx_avail_oe),
    .tx_space_n(tx_space_n),
    .tx_space_oe(tx_space_oe),
    .rx_byte(rx_byte),
    .rx_byte_ready(rx_byte_ready),
    .tx_byte(tx_byte),
    .tx_byte_ready(tx_byte_ready),
    .usb_req(usb_req)
  );
  afh_host_model host_u (.ref_clk(ref_clk), .rx_avail_n(rxf), .tx_space_n(txe),
    .dev_data(data_bus_out), .dev_oe(data_bus_oe), .rd_n(rd_n), .wr_n(wr_n),
    .bus(data_bus_in));
  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up;
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic need(input logic okv);
    if (okv !== 1'b1) begin
      err_total++;
      wrap_up();
    end
  endtask : need
  // usb side: feed receive bytes, drain transmit bytes with stalls, count pulses
  always @(posedge ref_clk) begin
    if (rx_byte_ready === 1'b1 && rx_q.size() > 0) void'(rx_q.pop_front());
    rx_byte <= '{valid: rx_q.size() > 0, data: rx_q.size() > 0 ? rx_q[0] : 8'h00};
    if (tx_byte.valid === 1'b1 && tx_byte_ready) chk(tx_byte.data, tx_exp.pop_front());
    tx_byte_ready <= drain_on & ~tx_byte_ready;
    n_res += int'(usb_req.resume_req === 1'b1);
    n_snd += int'(usb_req.send_now === 1'b1);
  end
  // main sequence
  initial begin
    resetn = 1'b0;
    cfg_mode = afh_pkg::AFH_MODE_OFF;
    cfg_remote_wake_en = 1'b0;
    power_active_n = 1'b0;
    send_now_wake_n = 1'b1;
    drain_on = 1'b0;
    {err_total, cmp_count, n_res, n_snd} = '0;
    seed = 16'h5242;
    repeat (8) @(posedge ref_clk);
    chk(8'({rx_avail_oe, tx_space_oe, rxf, txe}), 8'h03);
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      rx_q.push_back(seed[7:0]);
      rx_exp.push_back(seed[7:0]);
    end
    repeat (8) @(posedge ref_clk);
    chk(8'({data_bus_oe, rxf, txe}), 8'h03);
    cfg_mode <= afh_pkg::AFH_MODE_FIFO;
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      host_u.rd_byte(4 + int'(seed[1:0]), d, ok);
      need(ok);
      chk(d, rx_exp.pop_front());
    end
    repeat (4) @(posedge ref_clk);
    chk(8'(rxf), 8'h01);
    for (int i = 0; i < afh_pkg::TX_DEPTH + 1; i++) begin // fifo plus the output stage
      seed = lfsr(seed);
      tx_exp.push_back(seed[7:0]);
      host_u.wr_byte(5 + int'(seed[9:8]), seed[7:0], ok);
      need(ok);
    end
    chk(8'(txe), 8'h01);
    drain_on <= 1'b1;
    for (int n = 0; n < 200 && tx_exp.size() > 0; n++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk(8'({tx_exp.size() > 0, txe}), 8'h00);
    for (int k = 0; k < 3; k++) begin
      power_active_n <= k < 2;
      cfg_remote_wake_en <= k != 1;
      repeat (4) @(posedge ref_clk);
      r0 = n_res;
      s0 = n_snd;
      send_now_wake_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      send_now_wake_n <= 1'b1;
      repeat (10) @(posedge ref_clk);
      chk(8'(n_res - r0), 8'(k == 0));
      chk(8'(n_snd - s0), 8'(k == 2));
    end
    wrap_up();
  end
endmodule : afh_port_tb
`default_nettype wire
